// ---- pkg/ebpm_pkg.sv ----
// Shared constants and types of the pin multiplexer
package ebpm_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [15:0] SEL_REG_ADDR   = 16'h1c00;
    localparam logic [15:0] SEL_RESET      = 16'h0000;

    // Field positions of external_bus_select
    localparam int PP_ROUTE_LSB  = 12;
    localparam int PP_ROUTE_MSB  = 14;
    localparam int SP1_ROUTE_LSB = 10;
    localparam int SP1_ROUTE_MSB = 11;
    localparam int SP0_ROUTE_LSB = 8;
    localparam int SP0_ROUTE_MSB = 9;
    localparam int ADDR_SEL_LSB  = 0;
    localparam int ADDR_SEL_MSB  = 5;

    // ************************************************************
    // Pin counts and field codes
    // ************************************************************
    localparam int PP_PINS   = 21;
    localparam int ADDR_PINS = 6;

    localparam logic [2:0] PP_MODE1 = 3'h1;
    localparam logic [2:0] PP_MODE2 = 3'h2;
    localparam logic [2:0] PP_MODE3 = 3'h3;
    localparam logic [2:0] PP_MODE4 = 3'h4;
    localparam logic [2:0] PP_MODE5 = 3'h5;
    localparam logic [2:0] PP_MODE6 = 3'h6;

    localparam logic [1:0] SP_MODE_CARD  = 2'h0;
    localparam logic [1:0] SP_MODE_AUDIO = 2'h1;
    localparam logic [1:0] SP_MODE_GPIO  = 2'h2;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_SPI,
        SRC_UART,
        SRC_AUDIO2,
        SRC_AUDIO3,
        SRC_GPIO
    } ebpm_src_e;

    typedef struct packed {
        ebpm_src_e  src;
        logic [2:0] idx;
    } ebpm_map_s;

    typedef struct packed {
        logic [2:0]  pp_route;
        logic [1:0]  sp1_route;
        logic [1:0]  sp0_route;
        logic [5:0]  addr_sel;
        logic [15:0] rdata;
    } ebpm_state_s;

endpackage

// ---- hdl/ebpm_serial_port_mux.sv ----
// Six-pin serial port multiplexer: memory card, audio serial or GPIO
`timescale 1ns/100ps
module ebpm_serial_port_mux
(
    // Selection
    input  wire logic [1:0] route_i,
    // Pins
    input  wire logic [5:0] pin_in_i,
    output logic      [5:0] pin_out_o,
    output logic      [5:0] pin_oe_o,
    // Memory card
    input  wire logic [5:0] card_out_i,
    input  wire logic [5:0] card_oe_i,
    output logic      [5:0] card_in_o,
    // Audio serial
    input  wire logic [3:0] audio_out_i,
    input  wire logic [3:0] audio_oe_i,
    output logic      [3:0] audio_in_o,
    // General I/O lines, local index 0..5
    input  wire logic [5:0] gpio_out_i,
    input  wire logic [5:0] gpio_oe_i,
    output logic      [5:0] gpio_in_o
);

    always_comb
    begin
        pin_out_o  = '0;
        pin_oe_o   = '0;
        card_in_o  = '0;
        audio_in_o = '0;
        gpio_in_o  = '0;
        // Reserved code leaves all six pins undriven
        case (route_i)
            ebpm_pkg::SP_MODE_CARD:
            begin
                pin_out_o = card_out_i;
                pin_oe_o  = card_oe_i;
                card_in_o = pin_in_i;
            end
            ebpm_pkg::SP_MODE_AUDIO:
            begin
                pin_out_o       = {gpio_out_i[5:4], audio_out_i};
                pin_oe_o        = {gpio_oe_i[5:4], audio_oe_i};
                audio_in_o      = pin_in_i[3:0];
                gpio_in_o[5:4]  = pin_in_i[5:4];
            end
            ebpm_pkg::SP_MODE_GPIO:
            begin
                pin_out_o = gpio_out_i;
                pin_oe_o  = gpio_oe_i;
                gpio_in_o = pin_in_i;
            end
            default:
            begin
            end
        endcase
    end

endmodule

// ---- hdl/ebpm_pin_mux.sv ----
// External bus pin multiplexer with its selection register
`timescale 1ns/100ps

// Summary of operation
// [RQ1] Selection register decoded at 0x1C00
// [RQ2] New routing applies next clock cycle
// [RQ3] Parallel mode steers peripherals onto 21 pins
// [RQ4] Address select 1 makes pin GPIO
// [RQ5] Address select 0 keeps memory address
// [RQ6] Parallel mode bits 14:12, reset 000
// [RQ7] Mode 1: SPI7, GPIO6, UART4, audio2
// [RQ8] Mode 2: eight GPIO lines only
// [RQ9] Mode 3: SPI4 and third audio
// [RQ10] Mode 4: second audio and UART
// [RQ11] Mode 5: SPI4 and UART4
// [RQ12] Mode 6: SPI7, both audio, GPIO
// [RQ13] Bits 15, 7, 6 read zero
// [RQ14] Software gates peripheral clocks before change
// [RQ15] Software resets peripherals after change
// [RQ16] Software writes register once after boot
// [RQ17] Routing set by software, no straps
// [RQ18] Serial port 0 card/audio/GPIO modes
// [RQ19] Serial port 1 card/audio/GPIO modes
// [RQ20] Reserved codes leave pins undriven
module ebpm_pin_mux
#(
    parameter int ADDR_W = 16
)
(
    // Clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    // Register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [15:0]       wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [15:0]       rdata_o,
    // Parallel port pins
    input  wire logic [20:0]       pp_pin_in_i,
    output logic      [20:0]       pp_pin_out_o,
    output logic      [20:0]       pp_pin_oe_o,
    // SPI
    input  wire logic [6:0]        spi_out_i,
    input  wire logic [6:0]        spi_oe_i,
    output logic      [6:0]        spi_in_o,
    // UART
    input  wire logic [3:0]        uart_out_i,
    input  wire logic [3:0]        uart_oe_i,
    output logic      [3:0]        uart_in_o,
    // Second audio serial port
    input  wire logic [3:0]        audio_serial_second_out_i,
    input  wire logic [3:0]        audio_serial_second_oe_i,
    output logic      [3:0]        audio_serial_second_in_o,
    // Third audio serial port
    input  wire logic [3:0]        audio_serial_third_out_i,
    input  wire logic [3:0]        audio_serial_third_oe_i,
    output logic      [3:0]        audio_serial_third_in_o,
    // Parallel port general I/O lines
    input  wire logic [7:0]        pp_gpio_out_i,
    input  wire logic [7:0]        pp_gpio_oe_i,
    output logic      [7:0]        pp_gpio_in_o,
    // Serial port 0 pins
    input  wire logic [5:0]        sp0_pin_in_i,
    output logic      [5:0]        sp0_pin_out_o,
    output logic      [5:0]        sp0_pin_oe_o,
    // Serial port 0 sources
    input  wire logic [5:0]        memory_card_zero_out_i,
    input  wire logic [5:0]        memory_card_zero_oe_i,
    output logic      [5:0]        memory_card_zero_in_o,
    input  wire logic [3:0]        audio_serial_zero_out_i,
    input  wire logic [3:0]        audio_serial_zero_oe_i,
    output logic      [3:0]        audio_serial_zero_in_o,
    input  wire logic [5:0]        sp0_gpio_out_i,
    input  wire logic [5:0]        sp0_gpio_oe_i,
    output logic      [5:0]        sp0_gpio_in_o,
    // Serial port 1 pins
    input  wire logic [5:0]        sp1_pin_in_i,
    output logic      [5:0]        sp1_pin_out_o,
    output logic      [5:0]        sp1_pin_oe_o,
    // Serial port 1 sources
    input  wire logic [5:0]        memory_card_one_out_i,
    input  wire logic [5:0]        memory_card_one_oe_i,
    output logic      [5:0]        memory_card_one_in_o,
    input  wire logic [3:0]        audio_serial_one_out_i,
    input  wire logic [3:0]        audio_serial_one_oe_i,
    output logic      [3:0]        audio_serial_one_in_o,
    input  wire logic [5:0]        sp1_gpio_out_i,
    input  wire logic [5:0]        sp1_gpio_oe_i,
    output logic      [5:0]        sp1_gpio_in_o,
    // Upper address pins 15..20
    input  wire logic [5:0]        addr_pin_in_i,
    output logic      [5:0]        addr_pin_out_o,
    output logic      [5:0]        addr_pin_oe_o,
    input  wire logic [5:0]        memif_address_pins_i,
    input  wire logic [5:0]        addr_gpio_out_i,
    input  wire logic [5:0]        addr_gpio_oe_i,
    output logic      [5:0]        addr_gpio_in_o,
    // Current routing
    output logic      [2:0]        parallel_port_route_o,
    output logic      [1:0]        serial_port1_route_o,
    output logic      [1:0]        serial_port0_route_o,
    output logic      [5:0]        addr_gpio_select_o
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // Register address needs thirteen bits to decode
    if (ADDR_W < 13 || ADDR_W > 32)
    begin : g_bad_addr_w
        $error("ADDR_W must lie between 13 and 32");
    end

    // ************************************************************
    // Functions
    // ************************************************************
    // [RQ1] Register address decode
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        return a == ADDR_W'(ebpm_pkg::SEL_REG_ADDR);
    endfunction

    function automatic ebpm_pkg::ebpm_map_s mk(input ebpm_pkg::ebpm_src_e s,
                                              input logic [4:0] pin,
                                              input logic [4:0] base);
        ebpm_pkg::ebpm_map_s m;
        m.src = s;
        m.idx = 3'(pin - base);
        return m;
    endfunction

    // Pin-by-pin source of the parallel port for one mode
    function automatic ebpm_pkg::ebpm_map_s pp_map(input logic [2:0] mode,
                                                  input logic [4:0] pin);
        ebpm_pkg::ebpm_map_s m;
        m.src = ebpm_pkg::SRC_NONE;
        m.idx = 3'h0;
        case (mode)
            // [RQ7] [RQ12] Modes 1 and 6 share layout, except pins 13..16 (UART or third audio)
            ebpm_pkg::PP_MODE1, ebpm_pkg::PP_MODE6:
            begin
                if (pin <= 5'h06)
                    m = mk(ebpm_pkg::SRC_SPI, pin, 5'h00);
                else if (pin <= 5'h0c)
                    m = mk(ebpm_pkg::SRC_GPIO, pin, 5'h07);
                else if (pin <= 5'h10)
                    m = mk(mode == ebpm_pkg::PP_MODE1 ? ebpm_pkg::SRC_UART : ebpm_pkg::SRC_AUDIO3, pin, 5'h0d);
                else
                    m = mk(ebpm_pkg::SRC_AUDIO2, pin, 5'h11);
            end
            // [RQ8] Eight GPIO lines only
            ebpm_pkg::PP_MODE2:
            begin
                if (pin <= 5'h07)
                    m = mk(ebpm_pkg::SRC_GPIO, pin, 5'h00);
            end
            // [RQ9] Four SPI, third audio
            ebpm_pkg::PP_MODE3:
            begin
                if (pin <= 5'h03)
                    m = mk(ebpm_pkg::SRC_SPI, pin, 5'h00);
                else if (pin >= 5'h11)
                    m = mk(ebpm_pkg::SRC_AUDIO3, pin, 5'h11);
            end
            // [RQ10] Second audio and UART
            ebpm_pkg::PP_MODE4:
            begin
                if (pin >= 5'h0d && pin <= 5'h10)
                    m = mk(ebpm_pkg::SRC_UART, pin, 5'h0d);
                else if (pin >= 5'h11)
                    m = mk(ebpm_pkg::SRC_AUDIO2, pin, 5'h11);
            end
            // [RQ11] Four SPI and UART
            ebpm_pkg::PP_MODE5:
            begin
                if (pin <= 5'h03)
                    m = mk(ebpm_pkg::SRC_SPI, pin, 5'h00);
                else if (pin >= 5'h0d && pin <= 5'h10)
                    m = mk(ebpm_pkg::SRC_UART, pin, 5'h0d);
            end
            // [RQ20] Mode 0 and reserved code drive nothing
            default:
            begin
            end
        endcase
        return m;
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    ebpm_pkg::ebpm_state_s st_q;
    ebpm_pkg::ebpm_state_s st_d;
    logic [15:0]           sel_view;

    // [RQ13] Reserved bits always read zero
    assign sel_view = {1'b0, st_q.pp_route, st_q.sp1_route, st_q.sp0_route,
                       2'b00, st_q.addr_sel};

    always_comb
    begin
        st_d       = st_q;
        // Read data stands one cycle
        st_d.rdata = '0;
        if (rd_i && reg_hit(addr_i))
            st_d.rdata = sel_view;
        // [RQ6] Writable fields, reserved bits dropped
        if (wr_i && reg_hit(addr_i))
        begin
            st_d.pp_route  = wdata_i[ebpm_pkg::PP_ROUTE_MSB:ebpm_pkg::PP_ROUTE_LSB];
            st_d.sp1_route = wdata_i[ebpm_pkg::SP1_ROUTE_MSB:ebpm_pkg::SP1_ROUTE_LSB];
            st_d.sp0_route = wdata_i[ebpm_pkg::SP0_ROUTE_MSB:ebpm_pkg::SP0_ROUTE_LSB];
            st_d.addr_sel  = wdata_i[ebpm_pkg::ADDR_SEL_MSB:ebpm_pkg::ADDR_SEL_LSB];
        end
    end

    // [RQ17] Fixed reset value, no sampled straps
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            st_q <= '{pp_route:  ebpm_pkg::SEL_RESET[14:12],
                      sp1_route: ebpm_pkg::SEL_RESET[11:10],
                      sp0_route: ebpm_pkg::SEL_RESET[9:8],
                      addr_sel:  ebpm_pkg::SEL_RESET[5:0],
                      rdata:     16'h0000};
        else
            st_q <= st_d;
    end

    assign rdata_o               = st_q.rdata;
    assign parallel_port_route_o = st_q.pp_route;
    assign serial_port1_route_o  = st_q.sp1_route;
    assign serial_port0_route_o  = st_q.sp0_route;
    assign addr_gpio_select_o    = st_q.addr_sel;

    // ************************************************************
    // Parallel port routing
    // ************************************************************
    // No glitch filter: quiesce links before a write
    always_comb
    begin
        ebpm_pkg::ebpm_map_s m;
        m                        = '0;
        pp_pin_out_o             = '0;
        pp_pin_oe_o              = '0;
        spi_in_o                 = '0;
        uart_in_o                = '0;
        audio_serial_second_in_o = '0;
        audio_serial_third_in_o  = '0;
        pp_gpio_in_o             = '0;
        // [RQ3] Steer each of the 21 pins
        for (int p = 0; p < ebpm_pkg::PP_PINS; p++)
        begin
            // [RQ2] Routing taken from the registered field
            m = pp_map(st_q.pp_route, 5'(p));
            unique case (m.src)
                ebpm_pkg::SRC_SPI:
                begin
                    pp_pin_out_o[p]  = spi_out_i[m.idx];
                    pp_pin_oe_o[p]   = spi_oe_i[m.idx];
                    spi_in_o[m.idx]  = pp_pin_in_i[p];
                end
                ebpm_pkg::SRC_UART:
                begin
                    pp_pin_out_o[p]       = uart_out_i[m.idx[1:0]];
                    pp_pin_oe_o[p]        = uart_oe_i[m.idx[1:0]];
                    uart_in_o[m.idx[1:0]] = pp_pin_in_i[p];
                end
                ebpm_pkg::SRC_AUDIO2:
                begin
                    pp_pin_out_o[p] = audio_serial_second_out_i[m.idx[1:0]];
                    pp_pin_oe_o[p]  = audio_serial_second_oe_i[m.idx[1:0]];
                    audio_serial_second_in_o[m.idx[1:0]] = pp_pin_in_i[p];
                end
                ebpm_pkg::SRC_AUDIO3:
                begin
                    pp_pin_out_o[p] = audio_serial_third_out_i[m.idx[1:0]];
                    pp_pin_oe_o[p]  = audio_serial_third_oe_i[m.idx[1:0]];
                    audio_serial_third_in_o[m.idx[1:0]] = pp_pin_in_i[p];
                end
                ebpm_pkg::SRC_GPIO:
                begin
                    pp_pin_out_o[p]     = pp_gpio_out_i[m.idx];
                    pp_pin_oe_o[p]      = pp_gpio_oe_i[m.idx];
                    pp_gpio_in_o[m.idx] = pp_pin_in_i[p];
                end
                ebpm_pkg::SRC_NONE:
                begin
                    pp_pin_oe_o[p] = 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // Upper address pins
    // ************************************************************
    always_comb
    begin
        for (int i = 0; i < ebpm_pkg::ADDR_PINS; i++)
        begin
            // [RQ4] Select 1 hands the pin to GPIO
            if (st_q.addr_sel[i])
            begin
                addr_pin_out_o[i] = addr_gpio_out_i[i];
                addr_pin_oe_o[i]  = addr_gpio_oe_i[i];
                addr_gpio_in_o[i] = addr_pin_in_i[i];
            end
            // [RQ5] Select 0 keeps the memory address
            else
            begin
                addr_pin_out_o[i] = memif_address_pins_i[i];
                addr_pin_oe_o[i]  = 1'b1;
                addr_gpio_in_o[i] = 1'b0;
            end
        end
    end

    // ************************************************************
    // Serial ports
    // ************************************************************
    // [RQ18] Serial port 0 routing
    ebpm_serial_port_mux u_sp0
    (
        .route_i     (st_q.sp0_route),
        .pin_in_i    (sp0_pin_in_i),
        .pin_out_o   (sp0_pin_out_o),
        .pin_oe_o    (sp0_pin_oe_o),
        .card_out_i  (memory_card_zero_out_i),
        .card_oe_i   (memory_card_zero_oe_i),
        .card_in_o   (memory_card_zero_in_o),
        .audio_out_i (audio_serial_zero_out_i),
        .audio_oe_i  (audio_serial_zero_oe_i),
        .audio_in_o  (audio_serial_zero_in_o),
        .gpio_out_i  (sp0_gpio_out_i),
        .gpio_oe_i   (sp0_gpio_oe_i),
        .gpio_in_o   (sp0_gpio_in_o)
    );

    // [RQ19] Serial port 1 routing
    ebpm_serial_port_mux u_sp1
    (
        .route_i     (st_q.sp1_route),
        .pin_in_i    (sp1_pin_in_i),
        .pin_out_o   (sp1_pin_out_o),
        .pin_oe_o    (sp1_pin_oe_o),
        .card_out_i  (memory_card_one_out_i),
        .card_oe_i   (memory_card_one_oe_i),
        .card_in_o   (memory_card_one_in_o),
        .audio_out_i (audio_serial_one_out_i),
        .audio_oe_i  (audio_serial_one_oe_i),
        .audio_in_o  (audio_serial_one_in_o),
        .gpio_out_i  (sp1_gpio_out_i),
        .gpio_oe_i   (sp1_gpio_oe_i),
        .gpio_in_o   (sp1_gpio_in_o)
    );

endmodule

// ---- verification/ebpm_pin_mux_props.sv ----
// Concurrent checks on the pin multiplexer ports
`timescale 1ns/100ps
module ebpm_pin_mux_props
#(
    parameter int ADDR_W = 16
)
(
    // Clock, reset, register port
    input wire logic              core_clk_i,
    input wire logic              rst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [15:0]       wdata_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic [15:0]       rdata_o,
    // Pins and sources
    input wire logic [20:0]       pp_pin_oe_o,
    input wire logic [5:0]        sp0_pin_oe_o,
    input wire logic [5:0]        sp1_pin_oe_o,
    input wire logic [5:0]        addr_pin_out_o,
    input wire logic [5:0]        addr_pin_oe_o,
    input wire logic [5:0]        memif_address_pins_i,
    input wire logic [5:0]        addr_gpio_out_i,
    input wire logic [5:0]        addr_gpio_oe_i,
    // Fields
    input wire logic [2:0]        parallel_port_route_o,
    input wire logic [1:0]        serial_port1_route_o,
    input wire logic [1:0]        serial_port0_route_o,
    input wire logic [5:0]        addr_gpio_select_o
);
    // ****
    // Checks
    // ****
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    logic [12:0] flds;
    assign flds = {parallel_port_route_o, serial_port1_route_o, serial_port0_route_o, addr_gpio_select_o};

    sequence s_hit_wr;
        wr_i && addr_i == ebpm_pkg::SEL_REG_ADDR;
    endsequence
    sequence s_hit_rd;
        rd_i && addr_i == ebpm_pkg::SEL_REG_ADDR;
    endsequence

    AST_WR_LANDS: assert property (s_hit_wr |=> flds == {$past(wdata_i[14:8]), $past(wdata_i[5:0])})
        else $error("write not landed");
    AST_HOLD: assert property (!(wr_i && addr_i == ebpm_pkg::SEL_REG_ADDR) |=> $stable(flds))
        else $error("fields moved");
    AST_RD_WORD: assert property (s_hit_rd |=> rdata_o == {1'b0, $past(flds[12:6]), 2'b00, $past(flds[5:0])})
        else $error("read word wrong");
    AST_RD_ZERO: assert property (!(rd_i && addr_i == ebpm_pkg::SEL_REG_ADDR) |=> rdata_o == 16'h0000)
        else $error("stray read data");
    AST_ADDR_MEM: assert property (((addr_pin_out_o ^ memif_address_pins_i) & ~addr_gpio_select_o) == 6'h00
        && &(addr_pin_oe_o | addr_gpio_select_o))
        else $error("memory address lost");
    AST_ADDR_GPIO: assert property (((addr_pin_out_o ^ addr_gpio_out_i) & addr_gpio_select_o) == 6'h00
        && ((addr_pin_oe_o ^ addr_gpio_oe_i) & addr_gpio_select_o) == 6'h00)
        else $error("GPIO not routed");
    AST_PP_RSVD: assert property (parallel_port_route_o inside {3'h0, 3'h7} |-> pp_pin_oe_o == 21'h000000)
        else $error("parallel pins driven");
    AST_SP_RSVD: assert property ((serial_port0_route_o == 2'h3 |-> sp0_pin_oe_o == 6'h00)
        and (serial_port1_route_o == 2'h3 |-> sp1_pin_oe_o == 6'h00))
        else $error("serial pins driven");
    AST_PP_GPIO: assert property (parallel_port_route_o == 3'h2 |-> pp_pin_oe_o[20:8] == 13'h0000)
        else $error("upper pins driven");
endmodule

bind ebpm_pin_mux ebpm_pin_mux_props #(.ADDR_W(ADDR_W)) u_ebpm_pin_mux_props
(
    .core_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pp_pin_oe_o, .sp0_pin_oe_o, .sp1_pin_oe_o,
    .addr_pin_out_o, .addr_pin_oe_o, .memif_address_pins_i, .addr_gpio_out_i, .addr_gpio_oe_i,
    .parallel_port_route_o, .serial_port1_route_o, .serial_port0_route_o, .addr_gpio_select_o
);

// ---- verification/tb.sv ----
// Self-checking bench for the pin multiplexer
`timescale 1ns/100ps
module tb;
    // ****
    // Stimulus and expectations
    // ****
    typedef struct {
        logic [15:0] sel;
        logic [20:0] po;
        logic [20:0] pe;
        logic [6:0]  si;
        logic [3:0]  ui;
    } ebpm_row_s;
    localparam logic [15:0] ADR = 16'h1c00;
    ebpm_row_s   rows [8] = '{
        '{16'h8000, 21'h000000, 21'h000000, 7'h00, 4'h0},
        '{16'h15ff, 21'h0d3e55, 21'h1fffff, 7'h6b, 4'ha},
        '{16'h2a2a, 21'h00003c, 21'h0000ff, 7'h00, 4'h0},
        '{16'h3f15, 21'h180005, 21'h1e000f, 7'h0b, 4'h0},
        '{16'hc001, 21'h0d2000, 21'h1fe000, 7'h00, 4'ha},
        '{16'h5520, 21'h012005, 21'h01e00f, 7'h0b, 4'ha},
        '{16'h6a0c, 21'h0d9e55, 21'h1fffff, 7'h6b, 4'h0},
        '{16'h7f73, 21'h000000, 21'h000000, 7'h00, 4'h0}};
    logic [5:0]  sp_exp [4] = '{6'h2d, 6'h13, 6'h1e, 6'h00};
    logic        core_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [20:0] pin_in = 21'h01406b;
    logic [54:0] src = {6'h2a, 6'h15, 6'h1e, 4'h3, 6'h2d, 4'hc, 4'h6, 4'h9, 8'h3c, 7'h55};
    logic [7:0]  oe = 8'hff;
    logic [15:0] rdata;
    logic [15:0] d;
    logic [20:0] pp_out;
    logic [20:0] pp_oe;
    logic [6:0]  spi_in;
    logic [3:0]  uart_in;
    logic [5:0]  sp0_out;
    logic [5:0]  sp0_oe;
    logic [5:0]  sp1_out;
    logic [5:0]  adr_out;
    logic [5:0]  adr_oe;
    int          num_errors = 0;
    int          cmp_count = 0;

    always #2.5 core_clk_i = ~core_clk_i;

    ebpm_pin_mux u_ebpm_pin_mux
    (
        .core_clk_i, .rst_i, .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .pp_pin_in_i(pin_in), .pp_pin_out_o(pp_out), .pp_pin_oe_o(pp_oe),
        .spi_out_i(src[6:0]), .spi_oe_i(oe[6:0]), .spi_in_o(spi_in),
        .uart_out_i(src[18:15]), .uart_oe_i(oe[3:0]), .uart_in_o(uart_in),
        .audio_serial_second_out_i(src[22:19]), .audio_serial_second_oe_i(oe[3:0]), .audio_serial_second_in_o(),
        .audio_serial_third_out_i(src[26:23]), .audio_serial_third_oe_i(oe[3:0]), .audio_serial_third_in_o(),
        .pp_gpio_out_i(src[14:7]), .pp_gpio_oe_i(oe), .pp_gpio_in_o(),
        .sp0_pin_in_i(pin_in[5:0]), .sp0_pin_out_o(sp0_out), .sp0_pin_oe_o(sp0_oe),
        .memory_card_zero_out_i(src[32:27]), .memory_card_zero_oe_i(oe[5:0]), .memory_card_zero_in_o(),
        .audio_serial_zero_out_i(src[36:33]), .audio_serial_zero_oe_i(oe[3:0]), .audio_serial_zero_in_o(),
        .sp0_gpio_out_i(src[42:37]), .sp0_gpio_oe_i(oe[5:0]), .sp0_gpio_in_o(),
        .sp1_pin_in_i(pin_in[11:6]), .sp1_pin_out_o(sp1_out), .sp1_pin_oe_o(),
        .memory_card_one_out_i(src[32:27]), .memory_card_one_oe_i(oe[5:0]), .memory_card_one_in_o(),
        .audio_serial_one_out_i(src[36:33]), .audio_serial_one_oe_i(oe[3:0]), .audio_serial_one_in_o(),
        .sp1_gpio_out_i(src[42:37]), .sp1_gpio_oe_i(oe[5:0]), .sp1_gpio_in_o(),
        .addr_pin_in_i(pin_in[20:15]), .addr_pin_out_o(adr_out), .addr_pin_oe_o(adr_oe),
        .memif_address_pins_i(src[48:43]), .addr_gpio_out_i(src[54:49]), .addr_gpio_oe_i(oe[5:0]),
        .addr_gpio_in_o(), .parallel_port_route_o(), .serial_port1_route_o(), .serial_port0_route_o(),
        .addr_gpio_select_o()
    );

    // ****
    // Tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Entered just after a rising edge
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [15:0] a, output logic [15:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk_i);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic chk_rst();
        chk(pp_oe, 21'h000000); // parallel off
        chk(sp0_out, 6'h2d); // card routed
        chk(adr_out, 6'h15); // memory address
        chk(adr_oe, 6'h3f); // pins driven
        chk(rdata, 16'h0000); // read data cleared
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Run needs about forty cycles
    initial
    begin
        repeat (2000) @(posedge core_clk_i);
        num_errors++;
        close_out();
    end

    initial
    begin
        repeat (11) @(posedge core_clk_i);
        #1;
        chk_rst();
        @(posedge core_clk_i);
        rst_i <= 1'b0;
        rd_reg(ADR, d);
        chk(d, 16'h0000); // reset value
        $display("test reset done");
        // Static sources, one write per setup
        foreach (rows[i])
        begin
            wr_reg(ADR, rows[i].sel);
            rd_reg(ADR, d);
            chk(d, rows[i].sel & 16'h7f3f); // reserved bits zero
            chk(pp_out, rows[i].po); // pin values
            chk(pp_oe, rows[i].pe); // pin enables
            chk(spi_in, rows[i].si); // SPI input
            chk(uart_in, rows[i].ui); // UART input
            chk(sp0_out, sp_exp[rows[i].sel[9:8]]); // port 0 pins
            chk(sp1_out, sp_exp[rows[i].sel[11:10]]); // port 1 pins
            chk(sp0_oe, (rows[i].sel[9:8] == 2'h3) ? 6'h00 : 6'h3f); // port 0 enables
            chk(adr_out, (src[48:43] & ~rows[i].sel[5:0]) | (src[54:49] & rows[i].sel[5:0])); // addr pins
            chk(adr_oe, 6'h3f); // addr enables
        end
        $display("test routing table done");
        wr_reg(16'h1c01, 16'h1500);
        rd_reg(16'h1c01, d);
        chk(d, 16'h0000); // other address reads zero
        rd_reg(ADR, d);
        chk(d, 16'h7f33); // write elsewhere ignored
        $display("test decode done");
        wr_reg(ADR, 16'h6102);
        rd_reg(ADR, d);
        chk(d, 16'h6102); // read right after write
        @(posedge core_clk_i);
        src <= ~src;
        @(posedge core_clk_i);
        #1;
        chk(rdata, 16'h0000); // read data one cycle only
        chk(pp_out, 21'h1261aa); // inverted sources follow
        chk(adr_out, 6'h28); // inverted address mix
        @(posedge core_clk_i);
        oe <= 8'h00;
        @(posedge core_clk_i);
        #1;
        chk(pp_oe, 21'h000000); // enables from peripherals
        chk(adr_oe, 6'h3d); // GPIO enable passed
        $display("test sources done");
        @(posedge core_clk_i);
        oe <= 8'hff;
        src <= ~src;
        rst_i <= 1'b1;
        @(posedge core_clk_i);
        #1;
        chk_rst();
        @(posedge core_clk_i);
        rst_i <= 1'b0;
        rd_reg(ADR, d);
        chk(d, 16'h0000); // cleared by second reset
        $display("test second reset done");
        close_out();
    end
endmodule
